// *** pkg/dfesc_params.svh ***
// constants for the double fault escalation unit
`ifndef DFESC_PARAMS_SVH
`define DFESC_PARAMS_SVH

`define DFESC_VEC_DIVIDE      8'h00
`define DFESC_VEC_NMI         8'h02
`define DFESC_VEC_DF          8'h08
`define DFESC_VEC_CSO         8'h09
`define DFESC_VEC_BADTSS      8'h0A
`define DFESC_VEC_NOTPRES     8'h0B
`define DFESC_VEC_STACK       8'h0C
`define DFESC_VEC_GP          8'h0D
`define DFESC_VEC_PF          8'h0E
`define DFESC_DF_ERRCODE      32'h0000_0000
`define DFESC_SHUT_CYCLE_CODE 4'hA

`endif

// *** pkg/dfesc_pkg.sv ***
// types for the double fault escalation unit
package dfesc_pkg;

    typedef enum logic [1:0] {
        DFESC_BENIGN,
        DFESC_CONTRIB,
        DFESC_PAGE
    } dfesc_class_t;

    // one exception event as offered by the core
    typedef struct packed {
        logic [7:0] vector;
        logic       prefetch;    // raised by instruction prefetch
        logic       soft_int;    // software interrupt instruction
        logic       ext_int;     // maskable external interrupt
        logic       fpu_operand; // fault in coprocessor operand transfer
        logic [31:0] err_code;
        logic       has_err;
    } dfesc_exc_t;

    // what the core must deliver next
    typedef struct packed {
        logic [7:0]  vector;
        logic [31:0] err_code;
        logic        has_err;
        logic        abort;
        logic        ip_undef;
    } dfesc_dispatch_t;

    typedef enum logic [1:0] {
        DFESC_WAKE_NONE,
        DFESC_WAKE_NMI,
        DFESC_WAKE_SMI,
        DFESC_WAKE_INIT
    } dfesc_wake_t;

endpackage

// *** core/dfesc_sync.sv ***
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module dfesc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

`default_nettype wire

// *** core/dfesc_unit.sv ***
// double fault escalation and shutdown control
`timescale 1ns/1ps
`default_nettype none
`include "dfesc_params.svh"


module dfesc_unit (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        exc_valid,
    input  wire dfesc_pkg::dfesc_exc_t       exc_in,
    input  wire logic                        deliver_busy,
    input  wire logic                        deliver_done,
    input  wire logic                        handler_state_bad,
    input  wire logic                        in_nmi_handler,
    input  wire logic                        system_mgmt_mode,
    input  wire logic                        nmi_pin,
    input  wire logic                        system_mgmt_interrupt,
    input  wire logic                        init_pin,
    input  wire logic                        addr_bit20_mask_input,
    output logic                             disp_valid,
    output dfesc_pkg::dfesc_dispatch_t       disp_out,
    output logic                             halted,
    output logic                             shut_cycle,
    output logic [3:0]                       shut_cycle_code,
    output logic                             need_reset,
    output logic                             wake_valid,
    output dfesc_pkg::dfesc_wake_t           wake_kind,
    output logic                             a20_mask_valid,
    output logic                             a20_mask_level
);

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [3:0] pins_s;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    dfesc_sync #(.WIDTH(4)) u_sync (
        .clk   (clk),
        .rst_n (rst_n_q),
        .d     ({nmi_pin, system_mgmt_interrupt, init_pin,
                 addr_bit20_mask_input}),
        .q     (pins_s)
    );

    logic nmi_s;
    logic smi_s;
    logic init_s;
    logic a20_s;
    assign nmi_s  = pins_s[3];
    assign smi_s  = pins_s[2];
    assign init_s = pins_s[1];
    assign a20_s  = pins_s[0];

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    function automatic dfesc_pkg::dfesc_class_t classify(
        input dfesc_pkg::dfesc_exc_t e
    );
        classify = dfesc_pkg::DFESC_BENIGN;
        // interrupts never count, whatever vector they use
        if (!e.soft_int && !e.ext_int) begin
            case (e.vector)
                `DFESC_VEC_DIVIDE,
                `DFESC_VEC_BADTSS,
                `DFESC_VEC_NOTPRES,
                `DFESC_VEC_STACK,
                `DFESC_VEC_GP: classify = dfesc_pkg::DFESC_CONTRIB;
                `DFESC_VEC_PF: classify = dfesc_pkg::DFESC_PAGE;
                default:       classify = dfesc_pkg::DFESC_BENIGN;
            endcase
        end
    endfunction

    // retired vector 9 is folded into general protection
    function automatic dfesc_pkg::dfesc_exc_t remap(
        input dfesc_pkg::dfesc_exc_t e
    );
        remap = e;
        if (!e.soft_int && !e.ext_int &&
            (e.vector == `DFESC_VEC_CSO || e.fpu_operand)) begin
            remap.vector   = `DFESC_VEC_GP;
            remap.has_err  = 1'b1;
            remap.err_code = `DFESC_DF_ERRCODE;
        end
    endfunction

    function automatic logic escalates(
        input dfesc_pkg::dfesc_class_t first,
        input dfesc_pkg::dfesc_class_t second
    );
        escalates = 1'b0;
        case (first)
            dfesc_pkg::DFESC_CONTRIB:
                escalates = (second == dfesc_pkg::DFESC_CONTRIB);
            dfesc_pkg::DFESC_PAGE:
                escalates = (second != dfesc_pkg::DFESC_BENIGN);
            default:
                escalates = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // delivery tracking
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SHUT,
        ST_LOCKED
    } dfesc_state_t;

    dfesc_state_t            state_q;
    logic                    df_active_q;
    dfesc_pkg::dfesc_class_t first_class_q;
    logic                    first_valid_q;

    dfesc_pkg::dfesc_exc_t   exc_m;
    dfesc_pkg::dfesc_class_t exc_class;
    logic                    nested;
    logic                    do_df;
    logic                    do_shut;
    logic                    do_lock;

    assign exc_m     = remap(exc_in);
    assign exc_class = classify(exc_m);
    // prefetch faults stay outside the escalation table
    assign nested    = exc_valid && deliver_busy && first_valid_q &&
                       !exc_m.prefetch;
    assign do_shut   = nested && df_active_q && state_q == ST_RUN;
    assign do_df     = nested && !df_active_q && state_q == ST_RUN &&
                       escalates(first_class_q, exc_class);
    assign do_lock   = do_df && handler_state_bad;

    // one bit remembers a double fault delivery is in flight
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            df_active_q <= 1'b0;
        end else if (do_df && !do_lock) begin
            // a new escalation outranks the end of the old delivery
            df_active_q <= 1'b1;
        end else if (state_q != ST_RUN || deliver_done) begin
            df_active_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            first_valid_q <= 1'b0;
            first_class_q <= dfesc_pkg::DFESC_BENIGN;
        end else if (state_q != ST_RUN) begin
            first_valid_q <= 1'b0;
        end else if (exc_valid && !do_shut) begin
            // the latest thing being delivered is the new first
            first_valid_q <= 1'b1;
            first_class_q <= do_df ? dfesc_pkg::DFESC_CONTRIB : exc_class;
        end else if (deliver_done) begin
            first_valid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // dispatch output
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            disp_valid <= 1'b0;
            disp_out   <= '0;
        end else begin
            disp_valid <= exc_valid && state_q == ST_RUN &&
                          !do_shut && !do_lock;
            if (do_df) begin
                disp_out.vector   <= `DFESC_VEC_DF;
                disp_out.err_code <= `DFESC_DF_ERRCODE;
                disp_out.has_err  <= 1'b1;
                disp_out.abort    <= 1'b1;
                disp_out.ip_undef <= 1'b1;
            end else if (exc_valid) begin
                disp_out.vector   <= exc_m.vector;
                disp_out.err_code <= exc_m.err_code;
                disp_out.has_err  <= exc_m.has_err;
                disp_out.abort    <= 1'b0;
                disp_out.ip_undef <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // shutdown state
    // ------------------------------------------------------------
    logic reset_only_q;
    logic wake_any;

    assign wake_any = nmi_s || smi_s || init_s;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q      <= ST_RUN;
            reset_only_q <= 1'b0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (do_lock) begin
                        state_q <= ST_LOCKED;
                    end else if (do_shut) begin
                        state_q      <= ST_SHUT;
                        reset_only_q <= in_nmi_handler ||
                                        system_mgmt_mode;
                    end
                end
                ST_SHUT: begin
                    if (wake_any && !reset_only_q) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_LOCKED: state_q <= ST_LOCKED;
                default:   state_q <= ST_RUN;
            endcase
        end
    end

    assign halted     = state_q != ST_RUN;
    assign need_reset = state_q == ST_LOCKED ||
                        (state_q == ST_SHUT && reset_only_q);

    // the platform sees a single cycle per entry
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            shut_cycle      <= 1'b0;
            shut_cycle_code <= 4'h0;
        end else begin
            shut_cycle      <= do_shut && !do_lock;
            shut_cycle_code <= (do_shut && !do_lock) ?
                               `DFESC_SHUT_CYCLE_CODE : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // wake report and held events
    // ------------------------------------------------------------
    logic wake_fire;
    logic a20_last_q;
    logic a20_pend_q;
    logic a20_hold_q;

    assign wake_fire = state_q == ST_SHUT && wake_any && !reset_only_q;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wake_valid <= 1'b0;
            wake_kind  <= dfesc_pkg::DFESC_WAKE_NONE;
        end else begin
            wake_valid <= wake_fire;
            // init ranks above smi, smi above nmi
            if (wake_fire) begin
                wake_kind <= init_s ? dfesc_pkg::DFESC_WAKE_INIT :
                             smi_s  ? dfesc_pkg::DFESC_WAKE_SMI :
                                      dfesc_pkg::DFESC_WAKE_NMI;
            end
        end
    end

    // mask changes during shutdown are replayed two cycles after wake
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            a20_last_q     <= 1'b0;
            a20_pend_q     <= 1'b0;
            a20_hold_q     <= 1'b0;
            a20_mask_valid <= 1'b0;
            a20_mask_level <= 1'b0;
        end else begin
            a20_last_q     <= a20_s;
            a20_mask_valid <= 1'b0;
            a20_hold_q     <= wake_fire;
            if (a20_s != a20_last_q && halted) begin
                a20_pend_q <= 1'b1;
            end else if (state_q == ST_RUN && !a20_hold_q &&
                         (a20_pend_q || a20_s != a20_last_q)) begin
                a20_pend_q     <= 1'b0;
                a20_mask_valid <= 1'b1;
                a20_mask_level <= a20_s;
            end
        end
    end

endmodule

`default_nettype wire

// *** tb/dfesc_unit_monitor.sv ***
// assertion checker for the double fault escalation unit
`timescale 1ns/1ps
`default_nettype none
`include "dfesc_params.svh"

module dfesc_unit_monitor (
    input wire logic                       clk,
    input wire logic                       arst_n,
    input wire logic                       exc_valid,
    input wire dfesc_pkg::dfesc_exc_t      exc_in,
    input wire logic                       disp_valid,
    input wire dfesc_pkg::dfesc_dispatch_t disp_out,
    input wire logic                       halted,
    input wire logic                       shut_cycle,
    input wire logic [3:0]                 shut_cycle_code,
    input wire logic                       need_reset,
    input wire logic                       wake_valid,
    input wire logic                       a20_mask_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_df_code_zero: assert property (
        disp_valid && disp_out.vector == `DFESC_VEC_DF |-> disp_out.abort
        && disp_out.has_err && disp_out.ip_undef
        && disp_out.err_code == `DFESC_DF_ERRCODE)
        else $error("double fault dispatch malformed");
    a_no_vec_nine: assert property (
        disp_valid |-> disp_out.vector != `DFESC_VEC_CSO)
        else $error("vector 9 dispatched");
    a_shut_code_value: assert property (
        shut_cycle_code == (shut_cycle ? `DFESC_SHUT_CYCLE_CODE : 4'h0))
        else $error("shutdown cycle code wrong");
    a_shut_pulse_halt: assert property (
        shut_cycle |-> halted ##1 !shut_cycle)
        else $error("shutdown cycle not a halting pulse");
    a_halt_no_dispatch: assert property (
        halted && $past(halted) |-> !disp_valid)
        else $error("dispatch while halted");
    a_reset_only_wake: assert property (
        need_reset |-> halted && !wake_valid)
        else $error("wake while reset required");
    a_wake_ends_halt: assert property (
        wake_valid |-> ##[0:1] !halted)
        else $error("wake left unit halted");
    a_pending_held: assert property (
        halted |-> !a20_mask_valid)
        else $error("pending event handled in shutdown");
    a_prefetch_no_esc: assert property (
        exc_valid && exc_in.prefetch
        |=> !(disp_valid && disp_out.vector == `DFESC_VEC_DF)
        && !shut_cycle ##1 !shut_cycle)
        else $error("prefetch fault escalated");
    a_exc_answered: assert property (
        exc_valid && !halted && !exc_in.prefetch
        |-> ##[1:2] (disp_valid || shut_cycle || need_reset))
        else $error("exception not answered");
endmodule
`default_nettype wire

// *** tb/dfesc_platform.sv ***
// platform model reacting to the shutdown bus cycle with a wake pin
`timescale 1ns/1ps
`default_nettype none
`include "dfesc_params.svh"

module dfesc_platform #(
    parameter int DELAY = 20
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       shut_cycle,
    input  wire logic [3:0] shut_cycle_code,
    input  wire logic [1:0] wake_sel,
    output logic            nmi_pin,
    output logic            system_mgmt_interrupt,
    output logic            init_pin,
    output logic            lamp_on
);
    int cnt_q;
    // lamp stays lit until reset, like a front panel indicator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q   <= 0;
            lamp_on <= 1'b0;
        end else if (shut_cycle
                     && shut_cycle_code == `DFESC_SHUT_CYCLE_CODE) begin
            cnt_q   <= DELAY + 4;
            lamp_on <= 1'b1;
        end else if (cnt_q > 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    // selected pin held four cycles, after a slow platform reaction
    assign nmi_pin = wake_sel == 2'd1 && cnt_q inside {[1:4]};
    assign system_mgmt_interrupt = wake_sel == 2'd2 && cnt_q inside {[1:4]};
    assign init_pin = wake_sel == 2'd3 && cnt_q inside {[1:4]};
endmodule
`default_nettype wire

// *** tb/dfesc_unit_tb_top.sv ***
// testbench top for the double fault escalation unit
`timescale 1ns/1ps
`default_nettype none
`include "dfesc_params.svh"

module dfesc_unit_tb_top;
    logic clk = 1'b0, arst_n = 1'b0, exc_valid = 1'b0;
    logic deliver_busy = 1'b0, deliver_done = 1'b0, handler_state_bad = 1'b0;
    logic in_nmi_handler = 1'b0, system_mgmt_mode = 1'b0;
    logic addr_bit20_mask_input = 1'b0;
    logic fpu_op = 1'b0;
    logic [1:0] wake_sel = 2'd0;
    dfesc_pkg::dfesc_exc_t exc_in = '0;
    logic nmi_pin, system_mgmt_interrupt, init_pin, lamp_on;
    logic disp_valid, halted, shut_cycle, need_reset, wake_valid;
    logic a20_mask_valid, a20_mask_level;
    logic [3:0] shut_cycle_code;
    dfesc_pkg::dfesc_dispatch_t disp_out;
    dfesc_pkg::dfesc_wake_t wake_kind;
    int n_mismatch = 0;
    int n_checks = 0;
    logic got_d, got_s;
    logic [7:0] got_v;
    logic [31:0] got_e;

    always #2.5 clk = ~clk;

    dfesc_unit dut (.clk, .arst_n, .exc_valid, .exc_in, .deliver_busy,
        .deliver_done, .handler_state_bad, .in_nmi_handler, .system_mgmt_mode,
        .nmi_pin, .system_mgmt_interrupt, .init_pin, .addr_bit20_mask_input,
        .disp_valid, .disp_out, .halted, .shut_cycle, .shut_cycle_code,
        .need_reset, .wake_valid, .wake_kind, .a20_mask_valid,
        .a20_mask_level);
    dfesc_platform plat (.clk, .arst_n, .shut_cycle, .shut_cycle_code,
        .wake_sel, .nmi_pin, .system_mgmt_interrupt, .init_pin, .lamp_on);

    task automatic chk(input logic c, input string m);
        n_checks++;
        if (c !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'b0;
        deliver_busy = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    // one exception offered for one cycle, answer waited for boundedly
    task automatic offer(input logic [7:0] v, input logic pf,
                         input logic [1:0] fl, input logic b);
        @(negedge clk);
        exc_in = '0;
        exc_in.vector = v;
        exc_in.prefetch = pf;
        exc_in.soft_int = fl[1];
        exc_in.ext_int = fl[0];
        exc_in.fpu_operand = fpu_op;
        deliver_busy = b;
        exc_valid = 1'b1;
        @(negedge clk);
        exc_valid = 1'b0;
        got_d = 1'b0;
        got_s = 1'b0;
        for (int i = 0; i < 3 && !got_d && !got_s; i++) begin
            got_d = disp_valid === 1'b1;
            got_s = shut_cycle === 1'b1;
            got_v = disp_out.vector;
            got_e = disp_out.err_code;
            if (!got_d && !got_s) @(negedge clk);
        end
    endtask

    task automatic done_pulse();
        @(negedge clk);
        deliver_done = 1'b1;
        deliver_busy = 1'b0;
        @(negedge clk);
        deliver_done = 1'b0;
    endtask

    task automatic test_pairs();
        logic [7:0] fv [3] = '{8'h06, 8'h0D, 8'h0E};
        logic [7:0] sv [3] = '{8'h03, 8'h00, 8'h0E};
        logic esc;
        for (int f = 0; f < 3; f++) for (int s = 0; s < 3; s++) begin
            esc = (f == 1 && s == 1) || (f == 2 && s > 0);
            offer(fv[f], 1'b0, 2'b00, 1'b0);
            offer(sv[s], 1'b0, 2'b00, 1'b1);
            chk(got_d && got_v === (esc ? `DFESC_VEC_DF : sv[s]), "pair");
            if (esc) chk(got_e === `DFESC_DF_ERRCODE, "df code");
            done_pulse();
        end
        $display("test_pairs done");
    endtask

    task automatic test_benign();
        logic [7:0] bv [13] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
            8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h0D, 8'h0E};
        for (int i = 0; i < 13; i++) begin
            offer(bv[i], 1'b0, {i == 11, i == 12}, 1'b0);
            offer(8'h0D, 1'b0, 2'b00, 1'b1);
            chk(got_d && got_v === `DFESC_VEC_GP, "benign escalated");
            done_pulse();
        end
        $display("test_benign done");
    endtask

    task automatic test_misc();
        offer(`DFESC_VEC_CSO, 1'b0, 2'b00, 1'b0);
        chk(got_d && got_v === `DFESC_VEC_GP && got_e === 32'h0, "vec9");
        fpu_op = 1'b1;
        offer(8'h07, 1'b0, 2'b00, 1'b0);
        fpu_op = 1'b0;
        chk(got_d && got_v === `DFESC_VEC_GP, "fpu operand");
        offer(8'h0E, 1'b0, 2'b00, 1'b0);
        offer(8'h0D, 1'b1, 2'b00, 1'b1);
        chk(got_v !== `DFESC_VEC_DF && !got_s, "prefetch");
        done_pulse();
        $display("test_misc done");
    endtask

    task automatic test_shut(input logic [1:0] wk, input logic nh,
                             input logic sm);
        logic woke, a20_ok;
        dfesc_pkg::dfesc_wake_t kind;
        woke = 1'b0;
        a20_ok = 1'b0;
        kind = dfesc_pkg::DFESC_WAKE_NONE;
        in_nmi_handler = nh;
        system_mgmt_mode = sm;
        wake_sel = wk;
        offer(8'h0E, 1'b0, 2'b00, 1'b0);
        offer(8'h0D, 1'b0, 2'b00, 1'b1);
        chk(got_d && got_v === `DFESC_VEC_DF, "no double fault");
        offer(8'h03, 1'b0, 2'b00, 1'b1);
        chk(got_s && halted === 1'b1, "no shutdown");
        addr_bit20_mask_input = ~addr_bit20_mask_input;
        offer(8'h0D, 1'b0, 2'b00, 1'b1);
        chk(!got_d && !got_s, "taken while halted");
        repeat (40) begin
            @(negedge clk);
            if (wake_valid === 1'b1) begin
                woke = 1'b1;
                kind = wake_kind;
            end
            if (a20_mask_valid === 1'b1)
                a20_ok = a20_mask_level === addr_bit20_mask_input;
        end
        chk(lamp_on === 1'b1, "no indicator");
        if (nh || sm) begin
            chk(!woke && need_reset === 1'b1, "woke, reset needed");
            do_reset();
        end else begin
            chk(woke && kind === dfesc_pkg::dfesc_wake_t'(wk), "wake");
            chk(a20_ok && halted === 1'b0, "held event lost");
            done_pulse();
        end
        in_nmi_handler = 1'b0;
        system_mgmt_mode = 1'b0;
        wake_sel = 2'd0;
        $display("test_shut done");
    endtask

    task automatic test_locked();
        offer(8'h0E, 1'b0, 2'b00, 1'b0);
        handler_state_bad = 1'b1;
        offer(8'h0D, 1'b0, 2'b00, 1'b1);
        chk(!got_d && need_reset === 1'b1, "not locked");
        handler_state_bad = 1'b0;
        do_reset();
        chk(halted === 1'b0 && need_reset === 1'b0, "reset exit");
        $display("test_locked done");
    endtask

    initial begin
        #20000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        do_reset();
        test_pairs();
        test_benign();
        test_misc();
        test_shut(2'd1, 1'b0, 1'b0);
        test_shut(2'd2, 1'b0, 1'b0);
        test_shut(2'd3, 1'b0, 1'b0);
        test_shut(2'd1, 1'b1, 1'b0);
        test_shut(2'd2, 1'b0, 1'b1);
        test_locked();
        complete_run();
    end
endmodule

bind dfesc_unit dfesc_unit_monitor u_mon (.clk, .arst_n, .exc_valid,
    .exc_in, .disp_valid, .disp_out, .halted, .shut_cycle,
    .shut_cycle_code, .need_reset, .wake_valid, .a20_mask_valid);
`default_nettype wire
